//--- rtl/ocr_fetch.sv
// Purpose: walks video ram items and fetches glyph rows and control words
// Assumes: memories answer one cycle after a read strobe, even nibble is high
// Notes: position, size and colour fields of the control word are used downstream
//
// Overview of operation
// - control item addresses step F of glyph
// - bank bit picks 0800H or 0C00H rom bank
// - bank location reads back bit 0, rest zero
// - rom fetches stay within shared program memory
// - screen walk starts at bank 1 address 00H
// - last control word stays in force
// - position applies only to next character
// - glyph is 15 steps at offsets 0 to E
// - pattern word top bit selects rimming
// - plain glyph: bit 9 leftmost, 1 bright
// - rimmed glyph: 5 cells doubled plus rim
// - item top two bits give type code
// - return payload gives row and column bits
// - item built from even and odd nibbles
// - display enable at bit 0 of 31H
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
module ocr_fetch
	import ocr_pkg::*;
#(
	parameter int LINES = GLYPH_LINES
)
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [6:0] reg_addr,
	input wire logic [3:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [3:0] reg_rdata_ff,
	output logic char_rom_bank_select_ff,
	output logic display_enable_bit_ff,
	// display timing
	input wire logic vsync_start,
	input wire logic hsync_start,
	// video ram read port
	output ocr_vaddr_t vram_addr_ff,
	output logic vram_rd_ff,
	input wire logic [3:0] vram_nibble,
	// character rom read port
	output logic [11:0] rom_addr_ff,
	output logic rom_rd_ff,
	input wire logic [15:0] rom_data,
	// fetched results
	output ocr_glyph_t glyph_ff,
	output logic [15:0] ctrl_word_ff,
	output logic screen_done_ff
);

	if (LINES < 1 || LINES > GLYPH_LINES)
	begin : g_chk
		$error("LINES must be 1 to 15");
	end
	localparam logic [3:0] LAST_LINE = 4'(LINES - 1);

	function automatic logic [11:0] rom_at(input logic bank, input logic [5:0] code,
		input logic [3:0] step);
		rom_at = (bank ? CHAR_ROM_BANK1_BASE : CHAR_ROM_BANK0_BASE) | {2'h0, code, step};
	endfunction

	function automatic logic [GLYPH_DOTS-1:0] widen(input logic [RIM_CELLS-1:0] cells);
		logic [GLYPH_DOTS-1:0] w;
		w = '0;
		for (int i = 0; i < RIM_CELLS; i++)
		begin
			w[2*i] = cells[i];
			w[2*i+1] = cells[i];
		end
		widen = w;
	endfunction
	ocr_state_t state_ff;
	logic [3:0] hi_nib_ff;
	logic [3:0] line_ff;
	logic cr_seen_ff;
	logic is_ctrl_ff;
	logic pend_pos_ff;
	ocr_vaddr_t row_start_ff;
	ocr_vaddr_t cr_target_ff;

	ocr_item_t item;
	logic in_item;
	logic is_cr;
	logic line_end;
	logic scr_end;
	logic fetch;
	logic step_next;
	logic line_go;

	always_comb
	begin
		item = {hi_nib_ff, vram_nibble};
		in_item = state_ff == S_ITEM;
		is_cr = item.id[0];
		line_end = in_item && cr_seen_ff && !is_cr;
		scr_end = in_item && cr_seen_ff && is_cr;
		fetch = in_item && !cr_seen_ff && !is_cr;
		step_next = (in_item && !cr_seen_ff && is_cr) || state_ff == S_DATA;
		line_go = state_ff == S_IDLE && display_enable_bit_ff && hsync_start && !screen_done_ff;
	end

	// registers
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			char_rom_bank_select_ff <= 1'b0;
			display_enable_bit_ff <= 1'b0;
			reg_rdata_ff <= REG_READ_ZERO;
		end
		else
		begin
			if (reg_wr && reg_addr == ADDR_CHAR_ROM_BANK_REGISTER)
				char_rom_bank_select_ff <= reg_wdata[0];
			if (reg_wr && reg_addr == ADDR_DISPLAY_ENABLE)
				display_enable_bit_ff <= reg_wdata[0];
			if (reg_rd && reg_addr == ADDR_CHAR_ROM_BANK_REGISTER)
				reg_rdata_ff <= {3'h0, char_rom_bank_select_ff};
			else if (reg_rd && reg_addr == ADDR_DISPLAY_ENABLE)
				reg_rdata_ff <= {3'h0, display_enable_bit_ff};
			else
				reg_rdata_ff <= REG_READ_ZERO;
		end
	end

	// item walk through video ram
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_ff <= S_IDLE;
			vram_addr_ff <= VRAM_HOME;
			vram_rd_ff <= 1'b0;
			hi_nib_ff <= 4'h0;
			cr_seen_ff <= 1'b0;
			cr_target_ff <= VRAM_HOME;
		end
		else if (vsync_start || !display_enable_bit_ff)
		begin
			state_ff <= S_IDLE;
			vram_rd_ff <= 1'b0;
			cr_seen_ff <= 1'b0;
		end
		else
		begin
			case (state_ff)
				S_IDLE:
					if (line_go)
					begin
						vram_addr_ff <= row_start_ff;
						vram_rd_ff <= 1'b1;
						cr_seen_ff <= 1'b0;
						state_ff <= S_NIB1;
					end
				S_NIB1:
				begin
					vram_addr_ff.col[0] <= 1'b1;
					state_ff <= S_NIB2;
				end
				S_NIB2:
				begin
					hi_nib_ff <= vram_nibble;
					vram_rd_ff <= 1'b0;
					state_ff <= S_ITEM;
				end
				S_ITEM:
					if (line_end || scr_end)
						state_ff <= S_IDLE;
					else if (fetch)
						state_ff <= S_ROM;
					else
					begin
						// a return is held until the next item shows whether it is doubled
						cr_seen_ff <= 1'b1;
						cr_target_ff <= {item.id == ID_CR_BANK2, item.payload, 1'b0};
					end
				S_ROM:
					state_ff <= S_DATA;
				default:
					state_ff <= S_IDLE;
			endcase
			if (step_next)
			begin
				vram_addr_ff <= 8'(vram_addr_ff + 8'h1);
				vram_rd_ff <= 1'b1;
				state_ff <= S_NIB1;
			end
		end
	end

	// row and line bookkeeping
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			row_start_ff <= VRAM_HOME;
			line_ff <= 4'h0;
			screen_done_ff <= 1'b0;
		end
		else if (vsync_start)
		begin
			row_start_ff <= VRAM_HOME;
			line_ff <= 4'h0;
			screen_done_ff <= 1'b0;
		end
		else if (scr_end)
			screen_done_ff <= 1'b1;
		else if (line_end && line_ff == LAST_LINE)
		begin
			row_start_ff <= cr_target_ff;
			line_ff <= 4'h0;
		end
		else if (line_end)
			line_ff <= 4'(line_ff + 4'h1);
	end

	// character rom fetch
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rom_addr_ff <= CHAR_ROM_BANK0_BASE;
			rom_rd_ff <= 1'b0;
			is_ctrl_ff <= 1'b0;
		end
		else
		begin
			rom_rd_ff <= fetch && display_enable_bit_ff && !vsync_start;
			if (fetch)
			begin
				is_ctrl_ff <= item.id == ID_CONTROL;
				if (item.id == ID_CONTROL)
					rom_addr_ff <= rom_at(char_rom_bank_select_ff, item.payload, CTRL_STEP);
				else
					rom_addr_ff <= rom_at(char_rom_bank_select_ff, item.payload, line_ff);
			end
		end
	end

	// glyph and control word capture
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			glyph_ff <= '0;
			ctrl_word_ff <= 16'h0000;
			pend_pos_ff <= 1'b0;
		end
		else
		begin
			glyph_ff.valid <= 1'b0;
			if (vsync_start)
				glyph_ff.col <= 5'h00;
			else if (line_go)
				glyph_ff.col <= '1; // one below zero: first glyph of a line lands on column 0
			if (state_ff == S_DATA && is_ctrl_ff && !vsync_start)
			begin
				ctrl_word_ff <= rom_data;
				pend_pos_ff <= 1'b1;
			end
			else if (state_ff == S_DATA && !vsync_start)
			begin
				glyph_ff.valid <= 1'b1;
				glyph_ff.new_pos <= pend_pos_ff;
				pend_pos_ff <= 1'b0;
				glyph_ff.col <= 5'(glyph_ff.col + 5'h01);
				glyph_ff.rimmed <= rom_data[RIM_SEL_BIT];
				if (rom_data[RIM_SEL_BIT])
				begin
					glyph_ff.dots <= widen(rom_data[RIM_CELL_MSB:RIM_CELL_LSB]);
					glyph_ff.rim <= rom_data[GLYPH_DOTS-1:0];
				end
				else
				begin
					glyph_ff.dots <= rom_data[GLYPH_DOTS-1:0];
					glyph_ff.rim <= '0;
				end
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_even_read;
		vram_rd_ff && !vram_addr_ff.col[0];
	endsequence
	sequence s_odd_read;
		vram_rd_ff && vram_addr_ff.col[0];
	endsequence
	a_nibble_pair: assert property (s_even_read
		##0 (display_enable_bit_ff && !vsync_start) |=> s_odd_read)
		else $error("odd nibble read did not follow even read");
	a_bank_window: assert property (rom_rd_ff |-> (char_rom_bank_select_ff ?
		(rom_addr_ff >= CHAR_ROM_BANK1_BASE && rom_addr_ff[11:10] == 2'h3) :
		(rom_addr_ff >= CHAR_ROM_BANK0_BASE && rom_addr_ff <= CHAR_ROM_BANK0_LAST)))
		else $error("rom fetch outside selected bank");
	a_ctrl_step: assert property (rom_rd_ff && is_ctrl_ff |-> rom_addr_ff[3:0] == CTRL_STEP)
		else $error("control fetch not at step F");
	a_glyph_step: assert property (rom_rd_ff && !is_ctrl_ff |->
		rom_addr_ff[3:0] == line_ff && line_ff <= LAST_LINE)
		else $error("glyph step does not match line");
	a_bank_readback: assert property (reg_rd && reg_addr == ADDR_CHAR_ROM_BANK_REGISTER
		|=> reg_rdata_ff == {3'h0, $past(char_rom_bank_select_ff)})
		else $error("bank location read back wrong");
	a_screen_home: assert property (vsync_start |=> row_start_ff == VRAM_HOME
		&& line_ff == 4'h0 && !screen_done_ff)
		else $error("screen walk not rewound to home");
	a_plain_dots: assert property (state_ff == S_DATA && !is_ctrl_ff
		&& !rom_data[RIM_SEL_BIT] && !vsync_start |=> glyph_ff.valid && !glyph_ff.rimmed
		&& glyph_ff.dots == $past(rom_data[GLYPH_DOTS-1:0]))
		else $error("plain glyph dots wrong");
	a_rim_cells: assert property (state_ff == S_DATA && !is_ctrl_ff
		&& rom_data[RIM_SEL_BIT] && !vsync_start |=> glyph_ff.rimmed
		&& glyph_ff.dots[GLYPH_DOTS-1] == $past(rom_data[RIM_CELL_MSB])
		&& glyph_ff.dots[0] == $past(rom_data[RIM_CELL_LSB])
		&& glyph_ff.rim == $past(rom_data[GLYPH_DOTS-1:0]))
		else $error("rimmed glyph expansion wrong");
	a_ctrl_hold: assert property (!(state_ff == S_DATA && is_ctrl_ff)
		|=> $stable(ctrl_word_ff))
		else $error("control word changed without a control fetch");
	a_ctrl_no_char: assert property (state_ff == S_DATA && is_ctrl_ff && !vsync_start
		|=> !glyph_ff.valid ##1 !glyph_ff.valid)
		else $error("control item produced a character");
	a_pos_once: assert property (glyph_ff.valid && glyph_ff.new_pos |-> !pend_pos_ff)
		else $error("position flag not consumed by next character");
endmodule

//--- rtl/ocr_pkg.sv
// Purpose: shared constants and types of the on-screen character fetch block
// Assumes: 12-bit program memory addresses, 4-bit register file words
// Notes: video addresses are {bank2, row, column}
package ocr_pkg;
	// register file locations
	localparam logic [6:0] ADDR_CHAR_ROM_BANK_REGISTER = 7'h30;
	localparam logic [6:0] ADDR_DISPLAY_ENABLE = 7'h31;
	localparam logic [3:0] REG_READ_ZERO = 4'h0;
	// character rom layout
	localparam logic [11:0] CHAR_ROM_BANK0_BASE = 12'h800;
	localparam logic [11:0] CHAR_ROM_BANK0_LAST = 12'hbff;
	localparam logic [11:0] CHAR_ROM_BANK1_BASE = 12'hc00;
	localparam logic [11:0] CHAR_ROM_BANK1_LAST = 12'hf7f;
	localparam logic [3:0] CTRL_STEP = 4'hf;
	localparam int GLYPH_LINES = 15;
	localparam int GLYPH_DOTS = 10;
	localparam int RIM_CELLS = 5;
	// pattern word fields
	localparam int RIM_SEL_BIT = 15;
	localparam int RIM_CELL_MSB = 14;
	localparam int RIM_CELL_LSB = 10;
	// video item type codes
	localparam logic [1:0] ID_PATTERN = 2'h0;
	localparam logic [1:0] ID_CR_BANK1 = 2'h1;
	localparam logic [1:0] ID_CONTROL = 2'h2;
	localparam logic [1:0] ID_CR_BANK2 = 2'h3;

	typedef struct packed {
		logic bank2;
		logic [2:0] row;
		logic [3:0] col;
	} ocr_vaddr_t;

	typedef struct packed {
		logic [1:0] id;
		logic [5:0] payload;
	} ocr_item_t;

	typedef struct packed {
		logic valid;
		logic rimmed;
		logic new_pos;
		logic [4:0] col;
		logic [GLYPH_DOTS-1:0] dots;
		logic [GLYPH_DOTS-1:0] rim;
	} ocr_glyph_t;

	localparam ocr_vaddr_t VRAM_HOME = 8'h00;

	typedef enum logic [2:0] {S_IDLE, S_NIB1, S_NIB2, S_ITEM, S_ROM, S_DATA} ocr_state_t;
endpackage

//--- tb/ocr_fetch_tb.sv
// Purpose: self-checking bench for ocr_fetch, answering video and rom reads itself
// Assumes: LINES set to 2 so a screen takes three scan lines
// Notes: expected rom addresses, glyphs and reads are queued, a negedge monitor pops them
`timescale 1ns/10ps
module testbench;
	import ocr_pkg::*;
	logic clk = 0;
	logic sys_rst = 1;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic vsync_start = 0;
	logic hsync_start = 0;
	logic [6:0] reg_addr = 0;
	logic [3:0] reg_wdata = 0;
	logic [3:0] vram_nibble = 0;
	logic [3:0] reg_rdata_ff;
	logic [15:0] rom_data = 0;
	logic [15:0] ctrl_word_ff;
	logic bank_sel, en_bit, vram_rd_ff, rom_rd_ff, screen_done_ff;
	logic rd_seen = 0;
	ocr_vaddr_t vram_addr_ff;
	logic [11:0] rom_addr_ff;
	ocr_glyph_t glyph_ff;
	ocr_glyph_t gx;
	logic [7:0] vram [128];
	logic [31:0] rom_q[$];
	logic [31:0] gq[$];
	logic [31:0] rq[$];
	logic [31:0] seed = 32'he553;
	logic [31:0] rnd;
	int mismatches = 0;
	int compares = 0;
	wire logic [6:0] vidx = {vram_addr_ff.bank2, vram_addr_ff.row, vram_addr_ff.col[3:1]};

	always #20 clk = ~clk;

	ocr_fetch #(.LINES(2)) ocr_fetch_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
		.char_rom_bank_select_ff(bank_sel), .display_enable_bit_ff(en_bit),
		.vsync_start(vsync_start), .hsync_start(hsync_start), .vram_addr_ff(vram_addr_ff),
		.vram_rd_ff(vram_rd_ff), .vram_nibble(vram_nibble), .rom_addr_ff(rom_addr_ff),
		.rom_rd_ff(rom_rd_ff), .rom_data(rom_data), .glyph_ff(glyph_ff),
		.ctrl_word_ff(ctrl_word_ff), .screen_done_ff(screen_done_ff));

	// mixes address bits so rimmed and plain words both occur
	function automatic logic [15:0] word(logic [11:0] a);
		return {a[0] ^ a[4], a ^ 12'ha5c, a[3:1]};
	endfunction

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] gexp(logic [11:0] a, logic np, logic [4:0] c);
		logic [15:0] w;
		ocr_glyph_t g;
		w = word(a);
		g = '0;
		g.valid = 1'b1;
		g.rimmed = w[15];
		g.new_pos = np;
		g.col = c;
		g.dots = w[15] ? {{2{w[14]}}, {2{w[13]}}, {2{w[12]}}, {2{w[11]}}, {2{w[10]}}} : w[9:0];
		g.rim = w[15] ? w[9:0] : 10'h0;
		return 32'(g);
	endfunction

	task automatic check(logic [31:0] got, logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wr(logic [6:0] a, logic [3:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(logic [6:0] a, logic [3:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(32'(e));
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	// generous gap: a second hsync inside a walk would be ignored
	task automatic pulse(logic [1:0] v);
		@(posedge clk);
		{vsync_start, hsync_start} <= v;
		@(posedge clk);
		{vsync_start, hsync_start} <= 2'h0;
		repeat (80) @(posedge clk);
	endtask

	task automatic expect_screen(logic [11:0] b);
		for (int ln = 0; ln < 2; ln++)
		begin
			rom_q.push_back(32'(b | 12'h02f));
			rom_q.push_back(32'(b | 12'h050 | 12'(ln)));
			gq.push_back(gexp(b | 12'h050 | 12'(ln), 1'b1, 5'h0));
			rom_q.push_back(32'(b | 12'h170 | 12'(ln)));
			gq.push_back(gexp(b | 12'h170 | 12'(ln), 1'b0, 5'h1));
		end
		rom_q.push_back(32'(b | 12'h2a0));
		gq.push_back(gexp(b | 12'h2a0, 1'b0, 5'h0));
	endtask

	// even location carries the high nibble
	always @(posedge clk)
	begin
		rd_seen <= reg_rd;
		if (vram_rd_ff)
			vram_nibble <= vram_addr_ff.col[0] ? vram[vidx][3:0] : vram[vidx][7:4];
		if (rom_rd_ff)
			rom_data <= word(rom_addr_ff);
	end

	always @(negedge clk)
	begin
		if (rd_seen && rq.size() > 0)
			check(32'(reg_rdata_ff), rq.pop_front());
		if (rom_rd_ff === 1'b1)
			check(32'(rom_addr_ff), rom_q.size() > 0 ? rom_q.pop_front() : 32'hdead);
		if (glyph_ff.valid === 1'b1)
		begin
			gx = glyph_ff;
			if (gx.rimmed === 1'b0)
				gx.rim = 10'h0;
			check(32'(gx), gq.size() > 0 ? gq.pop_front() : 32'hdead);
		end
	end

	initial
	begin
		int n;
		vram = '{default: 8'h00};
		vram[0] = 8'h82;
		vram[1] = 8'h05;
		vram[2] = 8'h17;
		vram[3] = 8'h48;
		vram[8] = 8'h2a;
		vram[9] = 8'h40;
		vram[10] = 8'h40;
		// second screen returns into video bank 2 at the same row
		vram[72] = 8'h2a;
		vram[73] = 8'h40;
		vram[74] = 8'h40;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		rd(7'h30, 4'h0);
		rnd = xs();
		wr(7'h30, rnd[3:0] | 4'h1);
		rd(7'h30, 4'h1);
		wr(7'h2f, rnd[7:4]);
		rd(7'h2f, 4'h0);
		$display("register test done");
		for (int bk = 0; bk < 2; bk++)
		begin
			rnd = xs();
			wr(7'h31, 4'h0);
			if (bk == 1)
				vram[3] = 8'hc8;
			wr(7'h30, {rnd[3:1], bk[0]});
			wr(7'h31, 4'h1);
			rd(7'h31, 4'h1);
			check(32'(en_bit), 32'h1);
			check(32'(bank_sel), 32'(bk));
			expect_screen(bk[0] ? CHAR_ROM_BANK1_BASE : CHAR_ROM_BANK0_BASE);
			pulse(2'h2);
			repeat (3) pulse(2'h1);
			n = 0;
			while (screen_done_ff !== 1'b1 && n < 200)
			begin
				@(posedge clk);
				n++;
			end
			if (screen_done_ff !== 1'b1)
			begin
				mismatches++;
				break;
			end
			check(32'(ctrl_word_ff), 32'(word((bk[0] ? 12'hc00 : 12'h800) | 12'h02f)));
			check(32'(rom_q.size() + gq.size()), 32'h0);
			pulse(2'h2);
			check(32'(screen_done_ff), 32'h0);
			$display("screen test bank %0d done", bk);
		end
		give_verdict();
	end
endmodule
